// file: rtl/cob_pkg.sv
// package: register map, field layout and drive codes for the clock output bank
package cob_pkg;
  // register offsets
  localparam logic [7:0] OFS_DMODE_A = 8'h05;
  localparam logic [7:0] OFS_DMODE_B = 8'h06;
  localparam logic [7:0] OFS_DMODE_C = 8'h07;
  localparam logic [7:0] OFS_OEN_A   = 8'h08;
  // reset values
  localparam logic [7:0] RST_DMODE   = 8'h00;
  localparam logic [7:0] RST_OEN     = 8'h00;
  // field layout
  localparam int         FIELD_W     = 2;
  localparam int         PER_REG     = 4;
  // disable codes
  localparam logic [1:0] DIS_BOTH_LOW = 2'h0;
  localparam logic [1:0] DIS_DIFF_LOW = 2'h1;
  // leg drive of one output
  typedef enum logic [1:0] {
    COB_DRV_CLOCK,
    COB_DRV_BOTH_LOW,
    COB_DRV_DIFF_LOW,
    COB_DRV_HIGHZ
  } cob_drv_type;
  // register access request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } cob_req_type;
endpackage

// file: rtl/cob_out_gate.sv
// one output driver gate: swaps enabled/disabled only while the clock is low
`timescale 1ns/1ns
module cob_out_gate (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // buffered reference clock, already synchronised
  input  wire logic       ref_clk,
  // control
  input  wire logic       enable,
  input  wire logic [1:0] dis_code,
  // leg drive
  output logic            p_out,
  output logic            n_out,
  output logic            p_oe,
  output logic            n_oe,
  output logic            active
);
  logic en_r;
  cob_pkg::cob_drv_type drv;

  // state only changes while ref clock is low, so no pulse is cut
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_r <= 1'b0;
    end else if (!ref_clk) begin
      en_r <= enable;
    end
  end

  always_comb begin
    if (en_r) begin
      drv = cob_pkg::COB_DRV_CLOCK;
    end else begin
      unique case (dis_code)
        cob_pkg::DIS_BOTH_LOW: drv = cob_pkg::COB_DRV_BOTH_LOW;
        cob_pkg::DIS_DIFF_LOW: drv = cob_pkg::COB_DRV_DIFF_LOW;
        default:               drv = cob_pkg::COB_DRV_HIGHZ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p_out  <= 1'b0;
      n_out  <= 1'b0;
      p_oe   <= 1'b1;
      n_oe   <= 1'b1;
      active <= 1'b0;
    end else begin
      active <= en_r;
      p_oe   <= (drv != cob_pkg::COB_DRV_HIGHZ);
      n_oe   <= (drv != cob_pkg::COB_DRV_HIGHZ);
      p_out  <= (drv == cob_pkg::COB_DRV_CLOCK) & ref_clk;
      n_out  <= (drv == cob_pkg::COB_DRV_CLOCK) ? ~ref_clk : (drv == cob_pkg::COB_DRV_DIFF_LOW);
    end
  end

  property p_no_cut_pulse;
    @(posedge clk) disable iff (!reset_n) $changed(en_r) |-> !$past(ref_clk);
  endproperty
  a_no_cut_pulse: assert property (p_no_cut_pulse) else $error("enable changed while clock high");

  property p_diff_low;
    @(posedge clk) disable iff (!reset_n)
      (!en_r && dis_code == cob_pkg::DIS_DIFF_LOW) |=> (p_oe && n_oe && !p_out && n_out);
  endproperty
  a_diff_low: assert property (p_diff_low) else $error("differential low drive wrong");

  property p_both_low;
    @(posedge clk) disable iff (!reset_n)
      (!en_r && dis_code == cob_pkg::DIS_BOTH_LOW) |=> (p_oe && n_oe && !p_out && !n_out);
  endproperty
  a_both_low: assert property (p_both_low) else $error("both low drive wrong");

  property p_highz;
    @(posedge clk) disable iff (!reset_n) (!en_r && dis_code[1]) |=> (!p_oe && !n_oe);
  endproperty
  a_highz: assert property (p_highz) else $error("high impedance not applied");

  property p_clock_mode;
    @(posedge clk) disable iff (!reset_n) en_r |=> (p_oe && n_oe && active && (n_out == !p_out));
  endproperty
  a_clock_mode: assert property (p_clock_mode) else $error("enabled output not differential");
endmodule

// file: rtl/cob_bank.sv
// register bank and output gating of the clock output buffer
`timescale 1ns/1ns
module cob_bank #(
  parameter int NUM_OUT = 12
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // register access from the serial host port
  input  wire cob_pkg::cob_req_type req,
  input  wire logic                req_valid,
  output logic [7:0]               rd_data,
  // reference clock from the input buffer
  input  wire logic                ref_clk_in,
  // output leg drive
  output logic [NUM_OUT-1:0]       p_out,
  output logic [NUM_OUT-1:0]       n_out,
  output logic [NUM_OUT-1:0]       p_oe,
  output logic [NUM_OUT-1:0]       n_oe,
  output logic [NUM_OUT-1:0]       out_active
);
  localparam bit WIDE = (NUM_OUT > 8);

  logic [7:0] disable_mode_reg_a_r;
  logic [7:0] disable_mode_reg_b_r;
  logic [7:0] disable_mode_reg_c_r;
  logic [7:0] output_enable_reg_a_r;
  logic       ref_meta_r;
  logic       ref_sync_r;
  logic [23:0] codes;
  logic [NUM_OUT-1:0] en_vec;
  logic [NUM_OUT-1:0] active_w;

  function automatic logic hit(input cob_pkg::cob_req_type r, input logic [7:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  function automatic logic is_reg(input logic [7:0] ofs);
    is_reg = (ofs == cob_pkg::OFS_DMODE_A) || (ofs == cob_pkg::OFS_DMODE_B) ||
             (ofs == cob_pkg::OFS_DMODE_C) || (ofs == cob_pkg::OFS_OEN_A);
  endfunction

  // reference clock synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_meta_r <= 1'b0;
      ref_sync_r <= 1'b0;
    end else begin
      ref_meta_r <= ref_clk_in;
      ref_sync_r <= ref_meta_r;
    end
  end

  // disable code registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      disable_mode_reg_a_r <= cob_pkg::RST_DMODE;
      disable_mode_reg_b_r <= cob_pkg::RST_DMODE;
      disable_mode_reg_c_r <= cob_pkg::RST_DMODE;
    end else if (req_valid) begin
      if (hit(req, cob_pkg::OFS_DMODE_A)) begin
        disable_mode_reg_a_r <= req.data;
      end
      if (hit(req, cob_pkg::OFS_DMODE_B)) begin
        disable_mode_reg_b_r <= req.data;
      end
      if (WIDE && hit(req, cob_pkg::OFS_DMODE_C)) begin
        disable_mode_reg_c_r <= req.data;
      end
    end
  end

  // enable register; a new enable takes effect at the gate only while the clock is low, so software need not time its writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      output_enable_reg_a_r <= cob_pkg::RST_OEN;
    end else if (req_valid && hit(req, cob_pkg::OFS_OEN_A)) begin
      output_enable_reg_a_r <= req.data;
    end
  end

  // read data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 8'h00;
    end else if (req_valid && !req.wr) begin
      unique case (req.addr)
        cob_pkg::OFS_DMODE_A: rd_data <= disable_mode_reg_a_r;
        cob_pkg::OFS_DMODE_B: rd_data <= disable_mode_reg_b_r;
        cob_pkg::OFS_DMODE_C: rd_data <= WIDE ? disable_mode_reg_c_r : 8'h00;
        cob_pkg::OFS_OEN_A:   rd_data <= output_enable_reg_a_r;
        default:              rd_data <= 8'h00;
      endcase
    end
  end

  assign codes = {disable_mode_reg_c_r, disable_mode_reg_b_r, disable_mode_reg_a_r};

  // enable bits 0 and 1, and bits 8 and up, whose gates are in this bank but have no enable register, stay clear
  always_comb begin
    en_vec = '0;
    for (int i = 0; i < NUM_OUT && i < 8; i++) begin
      en_vec[i] = (i >= 2) ? output_enable_reg_a_r[i] : 1'b0;
    end
  end

  generate
    for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
      cob_out_gate u_gate (
        .clk      (clk),
        .reset_n  (reset_n),
        .ref_clk  (ref_sync_r),
        .enable   (en_vec[g]),
        .dis_code (codes[g*cob_pkg::FIELD_W +: cob_pkg::FIELD_W]),
        .p_out    (p_out[g]),
        .n_out    (n_out[g]),
        .p_oe     (p_oe[g]),
        .n_oe     (n_oe[g]),
        .active   (active_w[g])
      );
    end
  endgenerate

  assign out_active = active_w;

  property p_reset_disabled;
    @(posedge clk) disable iff (!reset_n) $rose(reset_n) |-> output_enable_reg_a_r == 8'h00;
  endproperty
  a_reset_disabled: assert property (p_reset_disabled) else $error("enable register not cleared");

  property p_write_b;
    @(posedge clk) disable iff (!reset_n)
      (req_valid && req.wr && req.addr == cob_pkg::OFS_DMODE_B) |=> disable_mode_reg_b_r == $past(req.data);
  endproperty
  a_write_b: assert property (p_write_b) else $error("register at 0x06 not written");

  property p_write_a;
    @(posedge clk) disable iff (!reset_n)
      (req_valid && req.wr && req.addr == cob_pkg::OFS_DMODE_A) |=> disable_mode_reg_a_r == $past(req.data);
  endproperty
  a_write_a: assert property (p_write_a) else $error("first disable register not written");

  property p_narrow_c;
    @(posedge clk) disable iff (!reset_n) !WIDE |-> disable_mode_reg_c_r == 8'h00;
  endproperty
  a_narrow_c: assert property (p_narrow_c) else $error("register at 0x07 present on narrow part");

  property p_read_en;
    @(posedge clk) disable iff (!reset_n)
      (req_valid && !req.wr && req.addr == cob_pkg::OFS_OEN_A) |=> rd_data == $past(output_enable_reg_a_r);
  endproperty
  a_read_en: assert property (p_read_en) else $error("enable register readback wrong");

  property p_write_c;
    @(posedge clk) disable iff (!reset_n)
      (req_valid && req.wr && req.addr == cob_pkg::OFS_DMODE_C) |=>
        disable_mode_reg_c_r == (WIDE ? $past(req.data) : cob_pkg::RST_DMODE);
  endproperty
  a_write_c: assert property (p_write_c) else $error("register at 0x07 write wrong");

  property p_write_en;
    @(posedge clk) disable iff (!reset_n)
      (req_valid && req.wr && req.addr == cob_pkg::OFS_OEN_A) |=> output_enable_reg_a_r == $past(req.data);
  endproperty
  a_write_en: assert property (p_write_en) else $error("enable register not written");

  property p_read_a;
    @(posedge clk) disable iff (!reset_n)
      (req_valid && !req.wr && req.addr == cob_pkg::OFS_DMODE_A) |=> rd_data == $past(disable_mode_reg_a_r);
  endproperty
  a_read_a: assert property (p_read_a) else $error("first disable register readback wrong");

  property p_read_b;
    @(posedge clk) disable iff (!reset_n)
      (req_valid && !req.wr && req.addr == cob_pkg::OFS_DMODE_B) |=> rd_data == $past(disable_mode_reg_b_r);
  endproperty
  a_read_b: assert property (p_read_b) else $error("register at 0x06 readback wrong");

  property p_read_c;
    @(posedge clk) disable iff (!reset_n)
      (req_valid && !req.wr && req.addr == cob_pkg::OFS_DMODE_C) |=>
        rd_data == (WIDE ? $past(disable_mode_reg_c_r) : 8'h00);
  endproperty
  a_read_c: assert property (p_read_c) else $error("register at 0x07 readback wrong");

  property p_read_unknown;
    @(posedge clk) disable iff (!reset_n)
      (req_valid && !req.wr && !is_reg(req.addr)) |=> rd_data == 8'h00;
  endproperty
  a_read_unknown: assert property (p_read_unknown) else $error("unknown offset read not zero");

  property p_rd_hold;
    @(posedge clk) disable iff (!reset_n) !(req_valid && !req.wr) |=> $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed without a read");

  property p_write_ignored;
    @(posedge clk) disable iff (!reset_n)
      (req_valid && req.wr && !is_reg(req.addr))
      |=> ($stable(disable_mode_reg_a_r) && $stable(disable_mode_reg_b_r)
           && $stable(disable_mode_reg_c_r) && $stable(output_enable_reg_a_r));
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write to unknown offset changed a register");

  property p_low_outs_off;
    @(posedge clk) disable iff (!reset_n) out_active[1:0] == 2'h0;
  endproperty
  a_low_outs_off: assert property (p_low_outs_off) else $error("output 0 or 1 entered clock mode");

  property p_high_outs_off;
    @(posedge clk) disable iff (!reset_n) (out_active >> 8) == '0;
  endproperty
  a_high_outs_off: assert property (p_high_outs_off) else $error("output 8 or above entered clock mode");
endmodule

// file: verif/cob_host_model.sv
// host side model: issues register writes and reads on the request port
`timescale 1ns/1ns
module cob_host_model (
  // clock
  input  wire logic                clk,
  // request port
  output cob_pkg::cob_req_type     req,
  output logic                     req_valid,
  input  wire logic [7:0]          rd_data
);
  initial begin
    req       = '0;
    req_valid = 1'b0;
  end
  // one-cycle request pulse, taken at the next rising edge
  task automatic put(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    req       <= '{wr: wr, addr: addr, data: data};
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    req       <= '{wr: 1'b0, addr: ~addr, data: ~data};
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    put(1'b1, addr, data);
  endtask
  // read data is registered on the taking edge
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    put(1'b0, addr, 8'h00);
    @(negedge clk);
    data = rd_data;
  endtask
endmodule

// file: verif/cob_bank_test.sv
// self-checking bench for the clock output register bank
`timescale 1ns/1ns
module cob_bank_test;
  logic                 clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 ref_clk_in = 1'b0;
  logic [2:0]           rdiv = 3'h0;
  cob_pkg::cob_req_type req;
  logic                 req_valid;
  logic [7:0]           rd_data;
  logic [11:0]          p_out, n_out, p_oe, n_oe, out_active;
  logic [7:0]           rd_data_nar;
  logic [7:0]           p_out_nar, n_out_nar, p_oe_nar, n_oe_nar, out_active_nar;
  int                   n_mismatch = 0;
  int                   comparisons = 0;
  int                   cyc = 0;

  cob_host_model host (.clk(clk), .req(req), .req_valid(req_valid), .rd_data(rd_data));
  cob_bank #(.NUM_OUT(12)) i_dut (.clk(clk), .reset_n(reset_n), .req(req), .req_valid(req_valid),
    .rd_data(rd_data), .ref_clk_in(ref_clk_in), .p_out(p_out), .n_out(n_out), .p_oe(p_oe),
    .n_oe(n_oe), .out_active(out_active));
  cob_bank #(.NUM_OUT(8)) i_dut_narrow (.clk(clk), .reset_n(reset_n), .req(req), .req_valid(req_valid),
    .rd_data(rd_data_nar), .ref_clk_in(ref_clk_in), .p_out(p_out_nar), .n_out(n_out_nar), .p_oe(p_oe_nar),
    .n_oe(n_oe_nar), .out_active(out_active_nar));

  initial begin
    forever #10 clk = ~clk;
  end
  // slow reference clock, period ten bank clocks
  always @(posedge clk) begin
    rdiv <= (rdiv == 3'h4) ? 3'h0 : rdiv + 3'h1;
    if (rdiv == 3'h4) ref_clk_in <= ~ref_clk_in;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(addr, d);
    check($sformatf("reg %h", addr), d, exp);
  endtask

  task automatic t_reset();
    rd_chk(8'h05, 8'h00);
    rd_chk(8'h06, 8'h00);
    rd_chk(8'h07, 8'h00);
    rd_chk(8'h08, 8'h00);
    check("oe", p_oe[7:0] & n_oe[7:0], 8'hFF);
    check("legs", p_out[7:0] | n_out[7:0] | out_active[7:0], 8'h00);
  endtask
  task automatic t_codes();
    host.wr(8'h05, 8'h5A);
    host.wr(8'h06, 8'hE4);
    host.wr(8'h07, 8'h01);
    host.wr(8'h03, 8'hFF);
    rd_chk(8'h05, 8'h5A);
    rd_chk(8'h06, 8'hE4);
    rd_chk(8'h07, 8'h01);
    check("narrow reg 07", rd_data_nar, 8'h00);
    rd_chk(8'h03, 8'h00);
    repeat (4) @(negedge clk);
    check("p_oe", p_oe[7:0], 8'h3C);
    check("n_oe", n_oe[8:1], 8'h9E);
    check("p_out", {3'h0, p_out[8], p_out[5:4], p_out[3:2]}, 8'h00);
    check("n_out", {3'h0, n_out[8], n_out[5:4], n_out[3:2]}, 8'h1B);
    check("narrow oe", p_oe_nar & n_oe_nar, 8'h3C);
    check("narrow legs", {4'h0, p_out_nar[5:4], n_out_nar[5:4]}, 8'h02);
  endtask
  task automatic t_enable();
    int w;
    logic hi;
    hi = 1'b0;
    host.wr(8'h08, 8'h04);
    rd_chk(8'h08, 8'h04);
    for (w = 0; w < 60 && out_active[2] !== 1'b1; w++) @(negedge clk);
    check("active", {6'h00, out_active[3:2]}, 8'h01);
    check("narrow active", out_active_nar, 8'h04);
    for (w = 0; w < 30; w++) begin
      @(negedge clk);
      hi = hi | (p_out[2] === 1'b1);
      check("diff", {6'h00, p_out[2] ^ n_out[2], p_oe[2] & n_oe[2]}, 8'h03);
    end
    check("toggle", {7'h00, hi}, 8'h01);
    host.wr(8'h08, 8'h00);
    for (w = 0; w < 60 && out_active[2] !== 1'b0; w++) @(negedge clk);
    @(negedge clk);
    check("off", {5'h00, out_active[2], p_out[2], n_out[2]}, 8'h01);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_codes();
    t_enable();
    tally_and_finish();
  end
endmodule
